// ---- rtl/rtccr_pkg.sv ----
// Package with register offsets, field positions, reset values and capture bit masks.
package rtccr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFF_CONTROL_TWO = 8'h01;
    localparam logic [7:0] OFF_CONTROL_THREE = 8'h02;
    localparam logic [7:0] OFF_CAPTURE_SECONDS = 8'h13;
    localparam logic [7:0] OFF_CAPTURE_MINUTES = 8'h14;
    localparam logic [7:0] OFF_CAPTURE_HOURS = 8'h15;
    localparam logic [7:0] OFF_CAPTURE_DAY = 8'h16;
    localparam logic [7:0] OFF_CAPTURE_MONTH = 8'h17;
    localparam logic [7:0] OFF_CAPTURE_YEAR = 8'h18;
    localparam logic [7:0] OFF_AGING_TRIM = 8'h19;
    localparam logic [7:0] OFF_MEM_ADDR_TOP = 8'h1A;
    localparam logic [7:0] OFF_MEM_ADDR_LOW = 8'h1B;
    localparam logic [7:0] OFF_MEM_WRITE_PORT = 8'h1C;
    localparam logic [7:0] OFF_MEM_READ_PORT = 8'h1D;
    // Control one field positions.
    localparam int BIT_CLOCK_TEST = 7;
    localparam int BIT_WRITE_ZERO = 6;
    localparam int BIT_STOP = 5;
    localparam int BIT_MID_LEVEL = 4;
    localparam int BIT_POWER_ON_RESET_OVERRIDE_SEQ_EN = 3;
    localparam int BIT_HOUR12 = 2;
    localparam int BIT_LONG_TICK = 1;
    localparam int BIT_SHORT_TICK = 0;
    localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
    localparam logic [3:0] AGING_TRIM_RST = 4'h8;
    localparam logic [7:0] MEM_ADDR_LOW_RST = 8'h00;
    // Capture register implemented-bit masks.
    localparam logic [7:0] MASK_SECONDS = 8'h7F;
    localparam logic [7:0] MASK_MINUTES = 8'h7F;
    localparam logic [7:0] MASK_HOURS = 8'h3F;
    localparam logic [7:0] MASK_DAY = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    localparam int BIT_MERIDIEM = 5;
    localparam int MEM_ADDR_W = 9;
    localparam int MEM_DEPTH = 512;
endpackage : rtccr_pkg

// ---- rtl/rtccr_mem.sv ----
// Battery-backed user memory with registered read data.
module rtccr_mem #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input wire logic clock,
    input wire logic clockEn,
    input wire logic wrEn,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wrData,
    output logic [DW-1:0] rdData
);
    logic [DW-1:0] store [0:(1<<AW)-1];

    // No reset: contents are undefined at power-on and survive resets.
    always_ff @(posedge clock) begin
        if (clockEn) begin
            if (wrEn) begin
                store[addr] <= wrData;
            end
            rdData <= store[addr];
        end
    end
endmodule // rtccr_mem

// ---- rtl/rtccr_regs.sv ----
// Control-one, timestamp capture, aging trim and user memory register bank.
// Contract
// - Unimplemented bits always read back as zero.
// - Undefined-reset bits start arbitrary and survive later resets.
// - Addresses 00h, 01h and 02h are the control registers; only 00h is implemented here, 01h and 02h read as zero.
// - Control one bit 7 selects normal or external clock test mode.
// - Bit 5 set stops timekeeping clock and clears divider chain asynchronously.
// - Clock output stays available at its fast settings while stopped.
// - Bit 4 set by timestamp mid level; stays until host clears it.
// - Bit 3 enables power-on-reset-override sequence reception; keep zero normally.
// - Bit 2 selects 24-hour (zero) or 12-hour counting.
// - Bit 1 enables the once-per-minute interrupt.
// - Bit 0 enables the once-per-second interrupt.
// - Capture seconds holds 0 to 59 in low seven bits.
// - Capture minutes holds 0 to 59.
// - Capture hours holds 1 to 12 plus meridiem bit in 12-hour mode.
// - Capture hours holds 0 to 23 in 24-hour mode.
// - Capture day holds 1 to 31.
// - Capture month holds 1 to 12.
// - Capture year holds 0 to 99 over eight bits.
module rtccr_regs
    import rtccr_pkg::*;
#(
    parameter int MEM_AW = rtccr_pkg::MEM_ADDR_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEn,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [rtccr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [rtccr_pkg::DATA_W-1:0] regWrData,
    output logic [rtccr_pkg::DATA_W-1:0] regRdData,
    input wire logic tsMidLevel,
    input wire logic captureStrobe,
    input wire logic [7:0] liveSeconds,
    input wire logic [7:0] liveMinutes,
    input wire logic [7:0] liveHours,
    input wire logic [7:0] liveDay,
    input wire logic [7:0] liveMonth,
    input wire logic [7:0] liveYear,
    output logic clockTestModeEn,
    output logic timekeepStop,
    output logic dividerClear,
    output logic clockOutKeepAlive,
    output logic timestampMidLevelFlag,
    output logic powerOnResetOverrideEn,
    output logic hour12Mode,
    output logic longTickIrqEn,
    output logic shortTickIrqEn,
    output logic [3:0] agingTrimField
);
    import rtccr_pkg::*;

    // The address registers are one top bit and one low byte, so only nine bits fit.
    if (MEM_AW != MEM_ADDR_W) begin : gBadMemWidth
        $error("rtccr_regs: memory address width must be nine");
    end

    // Pin-level mid-level detect passes two flops before use.
    logic midSync1_r;
    logic midSync2_r;
    logic captureSync1_r;
    logic captureSync2_r;
    logic captureSeen_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            midSync1_r <= 1'b0;
            midSync2_r <= 1'b0;
            captureSync1_r <= 1'b0;
            captureSync2_r <= 1'b0;
            captureSeen_r <= 1'b0;
        end else if (clockEn) begin
            midSync1_r <= tsMidLevel;
            midSync2_r <= midSync1_r;
            captureSync1_r <= captureStrobe;
            captureSync2_r <= captureSync1_r;
            captureSeen_r <= captureSync2_r;
        end
    end

    logic captureEvent;
    assign captureEvent = captureSync2_r & ~captureSeen_r;

    logic wrCtl;
    assign wrCtl = regWrite && (regAddr == OFF_CONTROL_ONE);

    // Control one, except the hardware-set mid-level flag.
    logic [7:0] controlOne_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            controlOne_r <= CONTROL_ONE_RST;
        end else if (clockEn && wrCtl) begin
            controlOne_r <= regWrData;
            // Bit 6 is held at zero regardless of what the host writes.
            controlOne_r[BIT_WRITE_ZERO] <= 1'b0;
            controlOne_r[BIT_MID_LEVEL] <= 1'b0;
        end
    end

    // Mid-level flag is sticky; a detection in the clear cycle wins.
    logic midFlag_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            midFlag_r <= 1'b0;
        end else if (clockEn) begin
            if (midSync2_r) begin
                midFlag_r <= 1'b1;
            end else if (wrCtl && !regWrData[BIT_MID_LEVEL]) begin
                midFlag_r <= 1'b0;
            end
        end
    end

    // Capture registers have no reset: undefined at power-on, kept across resets.
    logic [7:0] capSec_r;
    logic [7:0] capMin_r;
    logic [7:0] capHour_r;
    logic [7:0] capDay_r;
    logic [7:0] capMon_r;
    logic [7:0] capYear_r;
    always_ff @(posedge clock) begin
        if (clockEn && captureEvent) begin
            capSec_r <= liveSeconds & MASK_SECONDS;
            capMin_r <= liveMinutes & MASK_MINUTES;
            // Meridiem bit is an hour tens bit in 24-hour mode.
            capHour_r <= liveHours & MASK_HOURS;
            capDay_r <= liveDay & MASK_DAY;
            capMon_r <= liveMonth & MASK_MONTH;
            capYear_r <= liveYear & MASK_YEAR;
        end
    end

    // Aging trim and memory address registers.
    logic [3:0] aging_r;
    logic memTop_r;
    logic [7:0] memLow_r;
    logic memAccess;
    assign memAccess = (regWrite && regAddr == OFF_MEM_WRITE_PORT)
                    || (regRead && regAddr == OFF_MEM_READ_PORT);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aging_r <= AGING_TRIM_RST;
            memTop_r <= 1'b0;
            memLow_r <= MEM_ADDR_LOW_RST;
        end else if (clockEn) begin
            if (regWrite && regAddr == OFF_AGING_TRIM) begin
                aging_r <= regWrData[3:0];
            end
            if (regWrite && regAddr == OFF_MEM_ADDR_TOP) begin
                memTop_r <= regWrData[0];
            end
            if (regWrite && regAddr == OFF_MEM_ADDR_LOW) begin
                memLow_r <= regWrData;
            end else if (memAccess) begin
                // Auto-increment across the nine-bit space after each access.
                {memTop_r, memLow_r} <= {memTop_r, memLow_r} + 9'h001;
            end
        end
    end

    logic [MEM_AW-1:0] memAddr;
    assign memAddr = {memTop_r, memLow_r};
    logic [7:0] memRdData;
    rtccr_mem #(.AW(MEM_AW), .DW(8)) userMem (
        .clock(clock),
        .clockEn(clockEn),
        .wrEn(regWrite && regAddr == OFF_MEM_WRITE_PORT),
        .addr(memAddr),
        .wrData(regWrData),
        .rdData(memRdData)
    );

    // Read mux; unimplemented bits and unmapped addresses return zero.
    logic [7:0] rdNxt;
    always_comb begin
        rdNxt = 8'h00;
        unique case (regAddr)
            OFF_CONTROL_ONE: begin
                rdNxt = controlOne_r;
                rdNxt[BIT_WRITE_ZERO] = 1'b0;
                rdNxt[BIT_MID_LEVEL] = midFlag_r;
            end
            OFF_CAPTURE_SECONDS: rdNxt = capSec_r & MASK_SECONDS;
            OFF_CAPTURE_MINUTES: rdNxt = capMin_r & MASK_MINUTES;
            OFF_CAPTURE_HOURS: rdNxt = capHour_r & MASK_HOURS;
            OFF_CAPTURE_DAY: rdNxt = capDay_r & MASK_DAY;
            OFF_CAPTURE_MONTH: rdNxt = capMon_r & MASK_MONTH;
            OFF_CAPTURE_YEAR: rdNxt = capYear_r;
            OFF_AGING_TRIM: rdNxt = {4'h0, aging_r};
            OFF_MEM_ADDR_TOP: rdNxt = {7'h00, memTop_r};
            OFF_MEM_ADDR_LOW: rdNxt = memLow_r;
            default: rdNxt = 8'h00;
        endcase
    end

    // Read data comes straight from a flop. Memory data leaves its own register one
    // cycle after the access, so it is loaded a cycle later than register data.
    // Limitation: a register read in the cycle right after a memory read is dropped.
    logic readMem_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readMem_r <= 1'b0;
            regRdData <= 8'h00;
        end else if (clockEn) begin
            readMem_r <= regRead && regAddr == OFF_MEM_READ_PORT;
            if (readMem_r) begin
                regRdData <= memRdData;
            end else if (regRead) begin
                regRdData <= rdNxt;
            end
        end
    end

    // Registered control outputs.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clockTestModeEn <= 1'b0;
            timekeepStop <= 1'b0;
            dividerClear <= 1'b0;
            clockOutKeepAlive <= 1'b1;
            timestampMidLevelFlag <= 1'b0;
            powerOnResetOverrideEn <= 1'b0;
            hour12Mode <= 1'b0;
            longTickIrqEn <= 1'b0;
            shortTickIrqEn <= 1'b0;
            agingTrimField <= AGING_TRIM_RST;
        end else if (clockEn) begin
            clockTestModeEn <= controlOne_r[BIT_CLOCK_TEST];
            timekeepStop <= controlOne_r[BIT_STOP];
            // Divider clear is a level the chain uses as async clear.
            dividerClear <= controlOne_r[BIT_STOP];
            // Output clock is never gated by the stop bit.
            clockOutKeepAlive <= 1'b1;
            timestampMidLevelFlag <= midFlag_r;
            powerOnResetOverrideEn <= controlOne_r[BIT_POWER_ON_RESET_OVERRIDE_SEQ_EN];
            hour12Mode <= controlOne_r[BIT_HOUR12];
            longTickIrqEn <= controlOne_r[BIT_LONG_TICK];
            shortTickIrqEn <= controlOne_r[BIT_SHORT_TICK];
            agingTrimField <= aging_r;
        end
    end
endmodule // rtccr_regs

// ---- verif/rtccr_regs_monitor.sv ----
// Checker of the control-one register bank ports.
module rtccr_regs_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEn,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [rtccr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [rtccr_pkg::DATA_W-1:0] regWrData,
    input wire logic [rtccr_pkg::DATA_W-1:0] regRdData,
    input wire logic tsMidLevel,
    input wire logic clockTestModeEn,
    input wire logic timekeepStop,
    input wire logic dividerClear,
    input wire logic clockOutKeepAlive,
    input wire logic timestampMidLevelFlag,
    input wire logic hour12Mode,
    input wire logic shortTickIrqEn
);
    timeunit 1ns;
    timeprecision 1ps;
    import rtccr_pkg::*;
    // A write that clears the flag; kept as a net so that $past sees one signal.
    wire logic clrMid = clockEn && regWrite && regAddr == OFF_CONTROL_ONE
        && !regWrData[BIT_MID_LEVEL];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence ctlWrite;
        clockEn && regWrite && regAddr == OFF_CONTROL_ONE;
    endsequence
    sequence readAt(logic [7:0] a);
        clockEn && regRead && regAddr == a;
    endsequence
    // Outputs trail the stored register by one cycle, so the write is two edges back.
    property ctlBit(logic o, int b);
        ctlWrite ##1 clockEn |-> ##1 o == $past(regWrData[b], 2);
    endproperty
    chk_test_mode: assert property (ctlBit(clockTestModeEn, BIT_CLOCK_TEST))
        else $error("test mode output wrong");
    chk_stop_bit: assert property (ctlBit(timekeepStop, BIT_STOP))
        else $error("stop output wrong");
    chk_hour_mode: assert property (ctlBit(hour12Mode, BIT_HOUR12))
        else $error("hour mode output wrong");
    chk_sec_enable: assert property (ctlBit(shortTickIrqEn, BIT_SHORT_TICK))
        else $error("second enable wrong");
    chk_divider_clear: assert property (timekeepStop |-> dividerClear)
        else $error("divider not cleared while stopped");
    chk_clock_output_pin_alive: assert property (clockOutKeepAlive)
        else $error("clock output dropped");
    chk_mid_set: assert property ((tsMidLevel && clockEn)[*4] |=> timestampMidLevelFlag)
        else $error("mid flag not set");
    chk_mid_hold: assert property ($fell(timestampMidLevelFlag) |-> $past(clrMid, 2))
        else $error("mid flag dropped on its own");
    chk_write_zero: assert property (readAt(OFF_CONTROL_ONE) |=> !regRdData[BIT_WRITE_ZERO])
        else $error("bit six read as one");
    chk_unused_zero: assert property (readAt(OFF_CAPTURE_MONTH) |=> regRdData[7:5] == 3'h0)
        else $error("unused month bits nonzero");
endmodule // rtccr_regs_monitor
bind rtccr_regs rtccr_regs_monitor mon (.clock, .rst_n, .clockEn, .regWrite, .regRead,
    .regAddr, .regWrData, .regRdData, .tsMidLevel, .clockTestModeEn, .timekeepStop,
    .dividerClear, .clockOutKeepAlive, .timestampMidLevelFlag, .hour12Mode, .shortTickIrqEn);

// ---- verif/rtccr_host.sv ----
// Host model that issues byte reads and writes on the register port.
module rtccr_host (
    input wire logic clock,
    input wire logic [rtccr_pkg::DATA_W-1:0] regRdData,
    output logic regWrite,
    output logic regRead,
    output logic [rtccr_pkg::ADDR_W-1:0] regAddr,
    output logic [rtccr_pkg::DATA_W-1:0] regWrData
);
    timeunit 1ns;
    timeprecision 1ps;
    import rtccr_pkg::*;
    // Idle bus starts quiet.
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // Released lines show inverted values so stale data never looks valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= (a == OFF_CONTROL_ONE) ? (d & 8'hBF) : d;
        @(posedge clock);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    // Data is taken one cycle after the read is accepted.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(posedge clock);
        #1 q = regRdData;
    endtask
endmodule // rtccr_host

// ---- verif/rtc_control_register_map_tb_top.sv ----
// Self-checking bench of the control-one register bank.
module rtc_control_register_map_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rtccr_pkg::*;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
    int num_errors = 0;
    int cmp_count = 0;
    logic clock, rst_n, clockEn, tsMidLevel, captureStrobe, regWrite, regRead;
    logic [7:0] live [6];
    logic [7:0] regAddr, regWrData, regRdData, q;
    logic clockTestModeEn, timekeepStop, dividerClear, clockOutKeepAlive;
    logic timestampMidLevelFlag, powerOnResetOverrideEn, hour12Mode;
    logic longTickIrqEn, shortTickIrqEn;
    logic [3:0] agingTrimField;
    rtccr_host host (.clock, .regRdData, .regWrite, .regRead, .regAddr, .regWrData);
    rtccr_regs uut (.clock, .rst_n, .clockEn, .regWrite, .regRead, .regAddr, .regWrData,
        .regRdData, .tsMidLevel, .captureStrobe, .liveSeconds(live[0]),
        .liveMinutes(live[1]), .liveHours(live[2]), .liveDay(live[3]),
        .liveMonth(live[4]), .liveYear(live[5]), .clockTestModeEn, .timekeepStop,
        .dividerClear, .clockOutKeepAlive, .timestampMidLevelFlag, .powerOnResetOverrideEn,
        .hour12Mode, .longTickIrqEn, .shortTickIrqEn, .agingTrimField);
    // Free-running core clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_defaults();
        host.rd(OFF_CONTROL_ONE, q);
        `CHK(q, CONTROL_ONE_RST)
        host.rd(OFF_AGING_TRIM, q);
        `CHK(q, {4'h0, AGING_TRIM_RST})
        `CHK({clockOutKeepAlive, agingTrimField}, 5'h18)
    endtask
    // Each control bit alone; the host restores the override bit to zero afterwards.
    task automatic t_ctl_bits();
        int bits [6] = '{7, 5, 3, 2, 1, 0};
        for (int i = 0; i < 6; i++) begin
            host.wr(OFF_CONTROL_ONE, 8'h01 << bits[i]);
            host.rd(OFF_CONTROL_ONE, q);
            `CHK(q, 8'h01 << bits[i])
            `CHK({clockTestModeEn, timekeepStop, powerOnResetOverrideEn, hour12Mode,
                longTickIrqEn, shortTickIrqEn}, 6'h20 >> i)
            `CHK(dividerClear, bits[i] == 5)
        end
        host.wr(OFF_CONTROL_ONE, 8'h00);
        @(posedge clock);
        clockEn <= 1'b0;
        host.wr(OFF_CONTROL_ONE, 8'h01);
        clockEn <= 1'b1;
        host.rd(OFF_CONTROL_ONE, q);
        `CHK(q, 8'h00)
    endtask
    // The mid-level flag survives a one and the end of its cause, and only a zero clears it.
    task automatic t_mid();
        @(posedge clock);
        tsMidLevel <= 1'b1;
        repeat (6) @(posedge clock);
        tsMidLevel <= 1'b0;
        host.wr(OFF_CONTROL_ONE, 8'h10);
        host.rd(OFF_CONTROL_ONE, q);
        `CHK(q, 8'h10)
        host.wr(OFF_CONTROL_ONE, 8'h00);
        host.rd(OFF_CONTROL_ONE, q);
        `CHK({q, timestampMidLevelFlag}, 9'h000)
    endtask
    // Two captures, in 12 and 24 hour form, then a reset that must not touch them.
    task automatic t_capture();
        logic [7:0] sets [2][6] = '{'{8'h59, 8'h59, 8'h32, 8'h31, 8'h12, 8'h99},
            '{8'hD9, 8'h00, 8'h23, 8'h01, 8'h01, 8'h00}};
        logic [7:0] msk [6] = '{MASK_SECONDS, MASK_MINUTES, MASK_HOURS, MASK_DAY,
            MASK_MONTH, MASK_YEAR};
        for (int s = 0; s < 2; s++) begin
            @(posedge clock);
            live <= sets[s];
            captureStrobe <= 1'b1;
            repeat (4) @(posedge clock);
            captureStrobe <= 1'b0;
            live <= '{default: 8'h45};
            host.wr(OFF_CAPTURE_SECONDS, 8'h00);
            for (int i = 0; i < 6; i++) begin
                host.rd(OFF_CAPTURE_SECONDS + 8'(i), q);
                `CHK(q, sets[s][i] & msk[i])
            end
        end
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        host.rd(OFF_CAPTURE_HOURS, q);
        `CHK(q, 8'h23)
        host.rd(8'h30, q);
        `CHK(q, 8'h00)
    endtask
    // Nine-bit address with wrap from the top location, then auto-increment on read.
    task automatic t_mem();
        host.wr(OFF_MEM_ADDR_TOP, 8'hFF);
        host.rd(OFF_MEM_ADDR_TOP, q);
        `CHK(q, 8'h01)
        host.wr(OFF_MEM_ADDR_LOW, 8'hFF);
        host.wr(OFF_MEM_WRITE_PORT, 8'hA5);
        host.wr(OFF_MEM_WRITE_PORT, 8'h5A);
        host.wr(OFF_MEM_ADDR_TOP, 8'h01);
        host.wr(OFF_MEM_ADDR_LOW, 8'hFF);
        host.rd(OFF_MEM_READ_PORT, q);
        `CHK(q, 8'hA5)
        host.rd(OFF_MEM_READ_PORT, q);
        `CHK(q, 8'h5A)
    endtask
    // Watchdog far beyond the roughly 150 cycles the run needs.
    initial begin
        #100us;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        clockEn = 1'b1;
        tsMidLevel = 1'b0;
        captureStrobe = 1'b0;
        live = '{default: 8'h00};
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        t_defaults();
        t_ctl_bits();
        t_mid();
        t_capture();
        t_mem();
        tally_and_finish();
    end
endmodule // rtc_control_register_map_tb_top
